// >>> pkg/tmrb_pkg.sv
package tmrb_pkg;

  // ==========================================================
  // Register indices (byte address = index * 4)
  localparam logic [5:0] IDX_CTRLA = 6'h00;
  localparam logic [5:0] IDX_CTRLB = 6'h01;
  localparam logic [5:0] IDX_EVCTRL = 6'h04;
  localparam logic [5:0] IDX_IRQ_EN = 6'h05;
  localparam logic [5:0] IDX_IRQ_FLAG = 6'h06;
  localparam logic [5:0] IDX_STATUS = 6'h07;
  localparam logic [5:0] IDX_COUNT = 6'h0A;
  localparam logic [5:0] IDX_COMPARE = 6'h0C;

  // ==========================================================
  // Field positions
  localparam int CTRLA_EN_BIT = 0;
  localparam int CTRLA_CLK_LSB = 1;
  localparam int CTRLA_SYNC_BIT = 4;
  localparam int CTRLB_MODE_LSB = 0;
  localparam int CTRLB_OE_BIT = 4;
  localparam int CTRLB_INIT_BIT = 5;
  localparam int CTRLB_OUTPUT_SELECT_A_BIT = 6;
  localparam int EVCTRL_EI_BIT = 0;
  localparam int EVCTRL_EDGE_BIT = 4;
  localparam int EVCTRL_FILT_BIT = 6;
  localparam int FLAG_BIT = 0;
  localparam int RUN_BIT = 0;

  // ==========================================================
  // Encodings and reset values
  localparam logic [2:0] MODE_PERIODIC = 3'h0;
  localparam logic [2:0] MODE_SINGLE = 3'h6;
  localparam logic [2:0] MODE_PWM = 3'h7;
  localparam logic [1:0] CLK_FULL = 2'h0;
  localparam logic [1:0] CLK_HALF = 2'h1;
  localparam logic [1:0] CLK_COMP = 2'h2;
  localparam logic [15:0] COUNT_RESET = 16'h0000;
  localparam logic [15:0] COMPARE_RESET = 16'h0000;
  localparam int FILTER_SAMPLES = 4;

  // ==========================================================
  // Types
  typedef struct packed {
    logic enable;
    logic [1:0] clock_source_field;
    logic restart_with_companion;
    logic output_select_a;
    logic output_initial_level;
    logic output_drive_enable;
    logic [2:0] count_mode_field;
    logic event_input_enable;
    logic edge_select;
    logic filter_enable;
    logic irq_enable;
  } tmrb_ctrl_s;

  typedef enum logic [2:0] {
    SS_IDLE = 3'b001,
    SS_RUN = 3'b010,
    SS_HOLD = 3'b100
  } tmrb_ss_e;

endpackage

// >>> verilog/tmrb_tick_gen.sv
`timescale 1ns/1ps
module tmrb_tick_gen (
  input wire logic hclk,
  input wire logic hresetn,
  input wire logic enable,
  input wire logic [1:0] clock_source_field,
  input wire logic companion_timer_clock,
  output logic tick
);

  // ==========================================================
  // Divider
  logic half_q;

  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
      half_q <= 1'b0;
    else if (!enable)
      half_q <= 1'b0;
    else
      half_q <= ~half_q;
  end

  // ==========================================================
  // Source select; reserved code never ticks
  always_comb
  begin
    unique case (clock_source_field)
      tmrb_pkg::CLK_FULL: tick = enable;
      tmrb_pkg::CLK_HALF: tick = enable & half_q;
      tmrb_pkg::CLK_COMP: tick = enable & companion_timer_clock;
      default: tick = 1'b0;
    endcase
  end

endmodule

// >>> verilog/tmrb_noise_filter.sv
`timescale 1ns/1ps
module tmrb_noise_filter #(
  parameter int SAMPLES = tmrb_pkg::FILTER_SAMPLES
) (
  input wire logic hclk,
  input wire logic hresetn,
  input wire logic din,
  output logic dout
);

  // ==========================================================
  // Sample history on the undivided clock
  logic [SAMPLES-1:0] hist_q;
  logic dout_q;
  logic dout_d;

  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
      hist_q <= '0;
    else
      hist_q <= {hist_q[SAMPLES-2:0], din};
  end

  // Level moves once the whole history agrees; passed on unregistered so
  // the added latency stays at the four samples
  always_comb
  begin
    dout_d = dout_q;
    if (&hist_q)
      dout_d = 1'b1;
    else if (~|hist_q)
      dout_d = 1'b0;
  end

  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
      dout_q <= 1'b0;
    else
      dout_q <= dout_d;
  end

  assign dout = dout_d;

endmodule

// >>> verilog/tmrb_timer.sv
// Chosen here: the register offsets and the AHB-Lite register port.
`timescale 1ns/1ps
module tmrb_timer (
  input wire logic hclk,
  input wire logic hresetn,
  input wire logic hsel,
  input wire logic [31:0] haddr,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic [2:0] hsize,
  input wire logic [31:0] hwdata,
  input wire logic hready,
  output logic [31:0] hrdata,
  output logic hreadyout,
  output logic hresp,
  input wire logic event_in,
  input wire logic companion_timer_clock,
  input wire logic companion_restart,
  output logic waveform_output,
  output logic event_out,
  output logic irq
);

  // ==========================================================
  // Bus slave state
  logic wr_pend_q;
  logic rd_pend_q;
  logic [5:0] idx_q;
  logic [31:0] hrdata_q;
  logic hreadyout_q;
  logic ap_valid;

  // Programming model
  tmrb_pkg::tmrb_ctrl_s ctrl_q;
  logic [15:0] counter_value_q;
  logic [15:0] compare_capture_value_q;
  logic capture_flag_q;

  // Core state
  tmrb_pkg::tmrb_ss_e ss_q;
  logic en_q;
  logic lvl_q;
  logic trig_q;
  logic ss_hi_q;
  logic ss_hi_d;
  logic wo_q;
  logic wo_d;
  logic event_out_q;
  logic irq_q;
  logic tick;
  logic filt_lvl;
  logic evt_lvl;
  logic trig;
  logic en_start;
  logic ss_stop;
  logic hold_done;
  logic cap_set;
  logic pwm_lvl;
  logic [7:0] compare_low_byte;
  logic [7:0] compare_high_byte;
  logic [7:0] count_lo;
  logic is_single;

  function automatic logic wr_hit(input logic pend, input logic [5:0] idx,
                                  input logic [5:0] target);
    wr_hit = pend && (idx == target);
  endfunction

  // ==========================================================
  // Submodules
  tmrb_tick_gen u_tick (
    .hclk(hclk),
    .hresetn(hresetn),
    .enable(ctrl_q.enable),
    .clock_source_field(ctrl_q.clock_source_field),
    .companion_timer_clock(companion_timer_clock),
    .tick(tick)
  );

  tmrb_noise_filter #(
    .SAMPLES(tmrb_pkg::FILTER_SAMPLES)
  ) u_filt (
    .hclk(hclk),
    .hresetn(hresetn),
    .din(event_in),
    .dout(filt_lvl)
  );

  // ==========================================================
  // AHB-Lite address and data phases
  assign ap_valid = hsel && hready && htrans[1];

  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
    begin
      wr_pend_q <= 1'b0;
      rd_pend_q <= 1'b0;
      idx_q <= 6'h00;
    end
    else
    begin
      if (ap_valid)
        idx_q <= haddr[7:2];
      wr_pend_q <= ap_valid && hwrite;
      rd_pend_q <= ap_valid && !hwrite;
    end
  end

  // Reads take one wait state so a write just before is already visible
  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
      hreadyout_q <= 1'b1;
    else if (ap_valid && !hwrite)
      hreadyout_q <= 1'b0;
    else
      hreadyout_q <= 1'b1;
  end

  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
      hrdata_q <= 32'h0000_0000;
    else if (rd_pend_q)
    begin
      hrdata_q <= 32'h0000_0000;
      unique case (idx_q)
        tmrb_pkg::IDX_CTRLA:
        begin
          hrdata_q[tmrb_pkg::CTRLA_EN_BIT] <= ctrl_q.enable;
          hrdata_q[tmrb_pkg::CTRLA_CLK_LSB +: 2] <= ctrl_q.clock_source_field;
          hrdata_q[tmrb_pkg::CTRLA_SYNC_BIT] <= ctrl_q.restart_with_companion;
        end
        tmrb_pkg::IDX_CTRLB:
        begin
          hrdata_q[tmrb_pkg::CTRLB_MODE_LSB +: 3] <= ctrl_q.count_mode_field;
          hrdata_q[tmrb_pkg::CTRLB_OE_BIT] <= ctrl_q.output_drive_enable;
          hrdata_q[tmrb_pkg::CTRLB_INIT_BIT] <= ctrl_q.output_initial_level;
          hrdata_q[tmrb_pkg::CTRLB_OUTPUT_SELECT_A_BIT] <= ctrl_q.output_select_a;
        end
        tmrb_pkg::IDX_EVCTRL:
        begin
          hrdata_q[tmrb_pkg::EVCTRL_EI_BIT] <= ctrl_q.event_input_enable;
          hrdata_q[tmrb_pkg::EVCTRL_EDGE_BIT] <= ctrl_q.edge_select;
          hrdata_q[tmrb_pkg::EVCTRL_FILT_BIT] <= ctrl_q.filter_enable;
        end
        tmrb_pkg::IDX_IRQ_EN: hrdata_q[tmrb_pkg::FLAG_BIT] <= ctrl_q.irq_enable;
        tmrb_pkg::IDX_IRQ_FLAG: hrdata_q[tmrb_pkg::FLAG_BIT] <= capture_flag_q;
        tmrb_pkg::IDX_STATUS: hrdata_q[tmrb_pkg::RUN_BIT] <= (ss_q == tmrb_pkg::SS_RUN);
        tmrb_pkg::IDX_COUNT: hrdata_q[15:0] <= counter_value_q;
        tmrb_pkg::IDX_COMPARE: hrdata_q[15:0] <= compare_capture_value_q;
        default: hrdata_q <= 32'h0000_0000;
      endcase
    end
  end

  // ==========================================================
  // Control registers
  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
      ctrl_q <= '0;
    else
    begin
      if (wr_hit(wr_pend_q, idx_q, tmrb_pkg::IDX_CTRLA))
      begin
        ctrl_q.enable <= hwdata[tmrb_pkg::CTRLA_EN_BIT];
        ctrl_q.clock_source_field <= hwdata[tmrb_pkg::CTRLA_CLK_LSB +: 2];
        ctrl_q.restart_with_companion <= hwdata[tmrb_pkg::CTRLA_SYNC_BIT];
      end
      if (wr_hit(wr_pend_q, idx_q, tmrb_pkg::IDX_CTRLB))
      begin
        ctrl_q.count_mode_field <= hwdata[tmrb_pkg::CTRLB_MODE_LSB +: 3];
        ctrl_q.output_drive_enable <= hwdata[tmrb_pkg::CTRLB_OE_BIT];
        ctrl_q.output_initial_level <= hwdata[tmrb_pkg::CTRLB_INIT_BIT];
        ctrl_q.output_select_a <= hwdata[tmrb_pkg::CTRLB_OUTPUT_SELECT_A_BIT];
      end
      if (wr_hit(wr_pend_q, idx_q, tmrb_pkg::IDX_EVCTRL))
      begin
        ctrl_q.event_input_enable <= hwdata[tmrb_pkg::EVCTRL_EI_BIT];
        ctrl_q.edge_select <= hwdata[tmrb_pkg::EVCTRL_EDGE_BIT];
        ctrl_q.filter_enable <= hwdata[tmrb_pkg::EVCTRL_FILT_BIT];
      end
      if (wr_hit(wr_pend_q, idx_q, tmrb_pkg::IDX_IRQ_EN))
        ctrl_q.irq_enable <= hwdata[tmrb_pkg::FLAG_BIT];
    end
  end

  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
      compare_capture_value_q <= tmrb_pkg::COMPARE_RESET;
    else if (wr_hit(wr_pend_q, idx_q, tmrb_pkg::IDX_COMPARE))
      compare_capture_value_q <= hwdata[15:0];
  end

  // ==========================================================
  // Event input qualification
  assign evt_lvl = ctrl_q.filter_enable ? filt_lvl : event_in;
  assign is_single = (ctrl_q.count_mode_field == tmrb_pkg::MODE_SINGLE);
  // Short glitches below one clock are not seen: input is sampled, not latched
  assign trig = ctrl_q.enable && ctrl_q.event_input_enable && is_single
    && (ctrl_q.edge_select ? (lvl_q && !evt_lvl) : (!lvl_q && evt_lvl));

  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
    begin
      lvl_q <= 1'b0;
      trig_q <= 1'b0;
      en_q <= 1'b0;
    end
    else
    begin
      lvl_q <= evt_lvl;
      trig_q <= trig && (ss_q != tmrb_pkg::SS_HOLD);
      en_q <= ctrl_q.enable;
    end
  end

  assign en_start = ctrl_q.enable && !en_q && is_single
    && (counter_value_q != compare_capture_value_q);
  assign ss_stop = (ss_q == tmrb_pkg::SS_RUN)
    && (counter_value_q == compare_capture_value_q);
  assign hold_done = (ss_q == tmrb_pkg::SS_HOLD) && tick;

  // ==========================================================
  // Single-shot sequencer
  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
      ss_q <= tmrb_pkg::SS_IDLE;
    else if (!ctrl_q.enable || !is_single)
      ss_q <= tmrb_pkg::SS_IDLE;
    else
    begin
      unique case (ss_q)
        tmrb_pkg::SS_IDLE:
          if (trig_q || en_start)
            ss_q <= tmrb_pkg::SS_RUN;
        tmrb_pkg::SS_RUN:
          if (ss_stop)
            ss_q <= tmrb_pkg::SS_HOLD;
        tmrb_pkg::SS_HOLD:
          if (hold_done)
            ss_q <= tmrb_pkg::SS_IDLE;
      endcase
    end
  end

  // Pulse level: event-immediate when output select is set
  always_comb
  begin
    ss_hi_d = ss_hi_q;
    if (!ctrl_q.enable || !is_single || ss_stop)
      ss_hi_d = 1'b0;
    else if (trig && ctrl_q.output_select_a && (ss_q != tmrb_pkg::SS_HOLD))
      ss_hi_d = 1'b1;
    else if ((ss_q == tmrb_pkg::SS_IDLE) && (trig_q || en_start))
      ss_hi_d = 1'b1;
    else if (ss_q != tmrb_pkg::SS_RUN && !ctrl_q.output_select_a)
      ss_hi_d = 1'b0;
  end

  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
      ss_hi_q <= 1'b0;
    else
      ss_hi_q <= ss_hi_d;
  end

  // ==========================================================
  // Counter
  assign compare_low_byte = compare_capture_value_q[7:0];
  assign compare_high_byte = compare_capture_value_q[15:8];
  assign count_lo = counter_value_q[7:0];

  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
      counter_value_q <= tmrb_pkg::COUNT_RESET;
    else if (wr_hit(wr_pend_q, idx_q, tmrb_pkg::IDX_COUNT))
      counter_value_q <= hwdata[15:0];
    else if (ctrl_q.enable && ctrl_q.restart_with_companion && companion_restart)
      counter_value_q <= tmrb_pkg::COUNT_RESET;
    else if (ctrl_q.enable)
    begin
      unique case (ctrl_q.count_mode_field)
        tmrb_pkg::MODE_SINGLE:
          if ((ss_q == tmrb_pkg::SS_IDLE) && trig_q)
            counter_value_q <= tmrb_pkg::COUNT_RESET;
          else if ((ss_q == tmrb_pkg::SS_RUN) && tick && !ss_stop)
            counter_value_q <= counter_value_q + 16'h0001;
        tmrb_pkg::MODE_PWM:
          if (tick)
            counter_value_q <= (count_lo == compare_low_byte) ? tmrb_pkg::COUNT_RESET
              : {8'h00, count_lo + 8'h01};
        tmrb_pkg::MODE_PERIODIC:
          if (tick)
            counter_value_q <= (counter_value_q == compare_capture_value_q)
              ? tmrb_pkg::COUNT_RESET : counter_value_q + 16'h0001;
        default:
          if (tick)
            counter_value_q <= counter_value_q + 16'h0001;
      endcase
    end
  end

  // ==========================================================
  // Capture flag, event strobe and interrupt
  always_comb
  begin
    cap_set = 1'b0;
    if (ctrl_q.enable)
    begin
      unique case (ctrl_q.count_mode_field)
        tmrb_pkg::MODE_SINGLE: cap_set = ss_stop;
        tmrb_pkg::MODE_PWM: cap_set = tick && (count_lo == compare_low_byte);
        tmrb_pkg::MODE_PERIODIC:
          cap_set = tick && (counter_value_q == compare_capture_value_q);
        default: cap_set = 1'b0;
      endcase
    end
  end

  // Set wins over a same-cycle write-one-to-clear
  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
      capture_flag_q <= 1'b0;
    else if (cap_set)
      capture_flag_q <= 1'b1;
    else if (wr_hit(wr_pend_q, idx_q, tmrb_pkg::IDX_IRQ_FLAG) && hwdata[tmrb_pkg::FLAG_BIT])
      capture_flag_q <= 1'b0;
  end

  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
      event_out_q <= 1'b0;
    else
      event_out_q <= cap_set;
  end

  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
      irq_q <= 1'b0;
    else
      irq_q <= capture_flag_q && ctrl_q.irq_enable;
  end

  // ==========================================================
  // Waveform output
  // Compare changes while running can glitch the PWM shape
  assign pwm_lvl = ctrl_q.enable && (compare_low_byte != 8'h00)
    && (count_lo < compare_high_byte);

  always_comb
  begin
    if (!ctrl_q.output_drive_enable)
      wo_d = 1'b0;
    else if (is_single)
      wo_d = ss_hi_d;
    else if (ctrl_q.count_mode_field == tmrb_pkg::MODE_PWM)
      wo_d = pwm_lvl;
    else
      wo_d = ctrl_q.output_initial_level;
  end

  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
      wo_q <= 1'b0;
    else
      wo_q <= wo_d;
  end

  // ==========================================================
  // Outputs
  assign hrdata = hrdata_q;
  assign hreadyout = hreadyout_q;
  assign hresp = 1'b0;
  assign waveform_output = wo_q;
  assign event_out = event_out_q;
  assign irq = irq_q;

endmodule

// >>> bench/tmrb_monitor.sv
`timescale 1ns/1ps
module tmrb_monitor (
  input wire logic hclk,
  input wire logic hresetn,
  input wire logic hsel,
  input wire logic [31:0] haddr,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic [2:0] hsize,
  input wire logic [31:0] hwdata,
  input wire logic hready,
  input wire logic [31:0] hrdata,
  input wire logic hreadyout,
  input wire logic hresp,
  input wire logic event_in,
  input wire logic companion_timer_clock,
  input wire logic companion_restart,
  input wire logic waveform_output,
  input wire logic event_out,
  input wire logic irq
);
  // ==========================================================
  // Transfer decode
  logic rd_t;
  logic wr_t;
  assign rd_t = hsel && hready && htrans[1] && !hwrite;
  assign wr_t = hsel && hready && htrans[1] && hwrite;
  default clocking cb @(posedge hclk); endclocking
  default disable iff (!hresetn);
  // ==========================================================
  // Properties
  property p_okay; hresp == 1'b0; endproperty
  property p_rd_wait; rd_t |=> !hreadyout ##1 hreadyout; endproperty
  property p_wr_nowait; wr_t |=> hreadyout; endproperty
  property p_wait_cause; !hreadyout |-> $past(rd_t); endproperty
  property p_hi_zero; hrdata[31:16] == 16'h0000; endproperty
  // Flag clears and enable changes come only through writes, so irq drops only after one
  property p_irq_fall; $fell(irq) |-> $past(wr_t, 2) || $past(wr_t, 3) || $past(wr_t, 4);
  endproperty
  property p_irq_rise;
    $rose(irq) |-> event_out || $past(event_out) || $past(wr_t, 3) || $past(wr_t, 4);
  endproperty
  property p_rst_quiet;
    $rose(hresetn) |-> !waveform_output && !event_out && !irq && hreadyout;
  endproperty
  a_okay: assert property (p_okay) else $error("response not OKAY");
  a_rd_wait: assert property (p_rd_wait) else $error("read wait state wrong");
  a_wr_nowait: assert property (p_wr_nowait) else $error("write stalled");
  a_wait_cause: assert property (p_wait_cause) else $error("stall without read");
  a_hi_zero: assert property (p_hi_zero) else $error("upper read bits set");
  a_irq_fall: assert property (p_irq_fall) else $error("irq dropped alone");
  a_irq_rise: assert property (p_irq_rise) else $error("irq rose alone");
  a_rst_quiet: assert property (p_rst_quiet) else $error("outputs busy at reset");
  c_evo: cover property (event_out);
  c_irq: cover property ($rose(irq));
  c_wave: cover property ($rose(waveform_output));
endmodule

bind tmrb_timer tmrb_monitor u_mon (.hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr),
  .htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata), .hready(hready),
  .hrdata(hrdata), .hreadyout(hreadyout), .hresp(hresp), .event_in(event_in),
  .companion_timer_clock(companion_timer_clock), .companion_restart(companion_restart),
  .waveform_output(waveform_output), .event_out(event_out), .irq(irq));

// >>> bench/tmrb_partner.sv
`timescale 1ns/1ps
module tmrb_partner #(
  parameter int DIV = 3,
  parameter int TOP = 20
) (
  input wire logic hclk,
  input wire logic hresetn,
  input wire logic ev_lvl,
  output logic event_in,
  output logic companion_timer_clock,
  output logic companion_restart
);
  // ==========================================================
  // Companion prescaler and counter
  int div_q;
  int tally_q;
  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
    begin
      div_q <= 0;
      tally_q <= 0;
      companion_timer_clock <= 1'b0;
      companion_restart <= 1'b0;
    end
    else
    begin
      div_q <= (div_q == DIV - 1) ? 0 : div_q + 1;
      companion_timer_clock <= (div_q == DIV - 1);
      if (div_q == DIV - 1)
        tally_q <= (tally_q == TOP - 1) ? 0 : tally_q + 1;
      companion_restart <= (div_q == DIV - 1) && (tally_q == TOP - 1);
    end
  end
  // ==========================================================
  // Event source: levels change only on edges, held whole cycles
  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
      event_in <= 1'b0;
    else
      event_in <= ev_lvl;
  end
endmodule

// >>> bench/testbench.sv
`timescale 1ns/1ps
module testbench;
  // ==========================================================
  // Signals and model state
  logic hclk = 1'b0;
  logic hresetn = 1'b0;
  logic hsel = 1'b0;
  logic [31:0] haddr = 32'h00000000;
  logic [1:0] htrans = 2'h0;
  logic hwrite = 1'b0;
  logic [2:0] hsize = 3'h2;
  logic [31:0] hwdata = 32'h00000000;
  logic ev = 1'b0;
  logic [31:0] hrdata;
  logic hreadyout, hresp, event_in, ctk, crs, wf, event_out, irq;
  logic [31:0] rs = 32'h0000D0FD;
  logic [31:0] mdl [64];
  logic [31:0] q;
  logic [5:0] ix [9];
  int n_mismatch = 0;
  int checked = 0;
  int cyc = 0;
  int n_evo = 0;
  int w, dl, wd, hc, base;
  int ed [4];
  int cs [4];
  int pl [6];
  int ph [6];

  tmrb_timer dut (.hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr),
    .htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata), .hready(hreadyout),
    .hrdata(hrdata), .hreadyout(hreadyout), .hresp(hresp), .event_in(event_in),
    .companion_timer_clock(ctk), .companion_restart(crs), .waveform_output(wf),
    .event_out(event_out), .irq(irq));
  tmrb_partner u_far (.hclk(hclk), .hresetn(hresetn), .ev_lvl(ev), .event_in(event_in),
    .companion_timer_clock(ctk), .companion_restart(crs));

  initial
  begin
    forever #2.5 hclk = ~hclk;
  end

  always @(posedge hclk)
  begin
    cyc++;
    if (event_out === 1'b1)
      n_evo++;
    if (cyc == 20000)
    begin
      n_mismatch++;
      $display("[ERR] %0t run did not finish", $time);
      end_sim();
    end
  end

  // ==========================================================
  // Helpers
  function automatic logic [31:0] xs();
    rs = rs ^ (rs << 13);
    rs = rs ^ (rs >> 17);
    rs = rs ^ (rs << 5);
    return rs;
  endfunction

  function automatic logic [31:0] mk(input logic [5:0] i);
    case (i)
      tmrb_pkg::IDX_CTRLA: return 32'h00000017;
      tmrb_pkg::IDX_CTRLB: return 32'h00000077;
      tmrb_pkg::IDX_EVCTRL: return 32'h00000051;
      tmrb_pkg::IDX_IRQ_EN: return 32'h00000001;
      tmrb_pkg::IDX_COUNT, tmrb_pkg::IDX_COMPARE: return 32'h0000FFFF;
      default: return 32'h00000000;
    endcase
  endfunction

  task automatic cmp(input logic [31:0] got, input logic [31:0] exp);
    checked++;
    if (got !== exp)
    begin
      n_mismatch++;
      $display("[ERR] %0t got %h expected %h", $time, got, exp);
    end
  endtask

  task automatic ok(input logic c);
    checked++;
    if (c !== 1'b1)
    begin
      n_mismatch++;
      $display("[ERR] %0t value out of range", $time);
    end
  endtask

  // Single AHB transfer; waits on hready, never on a cycle count
  task automatic bus(input logic wr, input logic [5:0] i, input logic [31:0] d,
    output logic [31:0] r);
    @(posedge hclk);
    hsel <= 1'b1;
    haddr <= {24'h000000, i, 2'b00};
    htrans <= 2'h2;
    hwrite <= wr;
    do @(posedge hclk); while (hreadyout !== 1'b1);
    hsel <= 1'b0;
    htrans <= 2'h0;
    hwdata <= d;
    do @(posedge hclk); while (hreadyout !== 1'b1);
    r = hrdata;
  endtask

  task automatic wr(input logic [5:0] i, input logic [31:0] d);
    logic [31:0] r;
    bus(1'b1, i, d, r);
    mdl[i] = d & mk(i);
  endtask

  task automatic rd(input logic [5:0] i, output logic [31:0] r);
    bus(1'b0, i, 32'h00000000, r);
  endtask

  task automatic lvl(input logic v, input int n);
    @(posedge hclk);
    ev <= v;
    repeat (n) @(posedge hclk);
  endtask

  // Delay from the event level reaching the timer to the output rise, then pulse length
  task automatic trig(input logic v, output int d, output int p);
    lvl(v, 0);
    do begin @(posedge hclk); #1; end while (event_in !== v);
    d = 0;
    while (wf !== 1'b1 && d < 60) begin @(posedge hclk); #1; d++; end
    p = 0;
    while (wf === 1'b1 && p < 3000) begin @(posedge hclk); #1; p++; end
  endtask

  task automatic end_sim();
    $display("checked %0d mismatches %0d", checked, n_mismatch);
    if (n_mismatch == 0 && checked > 0)
      $display("[ PASS ]");
    else
      $display("[ FAIL ]");
    $finish;
  endtask

  // ==========================================================
  // Main sequence
  initial
  begin
    foreach (mdl[k]) mdl[k] = 32'h00000000;
    ix = '{tmrb_pkg::IDX_CTRLA, tmrb_pkg::IDX_CTRLB, tmrb_pkg::IDX_EVCTRL,
      tmrb_pkg::IDX_IRQ_EN, tmrb_pkg::IDX_IRQ_FLAG, tmrb_pkg::IDX_STATUS,
      tmrb_pkg::IDX_COUNT, tmrb_pkg::IDX_COMPARE, 6'h3F};
    ed = '{2, 2, 1, 6};
    cs = '{0, 1, 0, 2};
    repeat (16) @(posedge hclk);
    hresetn <= 1'b1;
    // Reset values, access kinds, unmapped word; enable kept off
    for (int k = 0; k < 9; k++)
    begin
      rd(ix[k], q);
      cmp(q, 32'h00000000);
      wr(ix[k], (k == 0) ? (xs() & 32'h00000016) : xs());
      rd(ix[k], q);
      cmp(q, mdl[ix[k]]);
    end
    // Single-shot, armed with counter at top so enabling alone starts nothing
    w = 12 + int'(xs() % 8);
    wr(tmrb_pkg::IDX_COMPARE, 32'(w));
    wr(tmrb_pkg::IDX_COUNT, 32'(w));
    wr(tmrb_pkg::IDX_CTRLB, 32'h00000016);
    wr(tmrb_pkg::IDX_EVCTRL, 32'h00000001);
    wr(tmrb_pkg::IDX_IRQ_EN, 32'h00000001);
    wr(tmrb_pkg::IDX_CTRLA, 32'h00000001);
    repeat (8) @(posedge hclk);
    cmp({31'h0, wf}, 32'h00000000);
    rd(tmrb_pkg::IDX_STATUS, q);
    cmp(q, 32'h00000000);
    for (int k = 0; k < 4; k++)
    begin
      wr(tmrb_pkg::IDX_CTRLB, 32'h00000016 | (32'(k == 2) << 6));
      wr(tmrb_pkg::IDX_EVCTRL, 32'h00000001 | (32'(k % 2) << 4) | (32'(k == 3) << 6));
      wr(tmrb_pkg::IDX_CTRLA, 32'h00000001 | (32'(cs[k]) << 1));
      base = n_evo;
      fork
        trig(~ev, dl, wd);
        begin
          repeat (12) @(posedge hclk);
          rd(tmrb_pkg::IDX_STATUS, q);
          cmp(q, 32'h00000001);
        end
      join
      cmp(32'(dl), 32'(ed[k]));
      ok(wd > (w - 1) * (cs[k] + 1) + 1
        && wd <= w * (cs[k] + 1) + 1 + (k == 2));
      rd(tmrb_pkg::IDX_IRQ_FLAG, q);
      cmp(q, 32'h00000001);
      cmp({31'h0, irq}, 32'h00000001);
      cmp(32'(n_evo - base), 32'h00000001);
      wr(tmrb_pkg::IDX_IRQ_FLAG, 32'h00000001);
      rd(tmrb_pkg::IDX_IRQ_FLAG, q);
      cmp(q, 32'h00000000);
      rd(tmrb_pkg::IDX_STATUS, q);
      cmp(q, 32'h00000000);
      cmp({31'h0, irq}, 32'h00000000);
    end
    // Event input disabled, then a three-cycle glitch into the filter
    wr(tmrb_pkg::IDX_EVCTRL, 32'h00000000);
    lvl(1'b1, 10);
    cmp({31'h0, wf}, 32'h00000000);
    wr(tmrb_pkg::IDX_EVCTRL, 32'h00000041);
    lvl(1'b0, 10);
    lvl(1'b1, 2);
    lvl(1'b0, 12);
    cmp({31'h0, wf}, 32'h00000000);
    // Enable with counter below top starts a pulse without any event
    wr(tmrb_pkg::IDX_CTRLA, 32'h00000000);
    wr(tmrb_pkg::IDX_COUNT, 32'h00000000);
    wr(tmrb_pkg::IDX_CTRLA, 32'h00000001);
    trig(ev, dl, wd);
    ok(dl < 8);
    cmp(32'(wd), 32'(w));
    wr(tmrb_pkg::IDX_IRQ_FLAG, 32'h00000001);
    // PWM: whole periods are counted, so the phase of the window does not matter
    pl = '{5, 5, 5, 0, 255, 1 + int'(xs() % 30)};
    ph = '{2, 0, 6, 3, 128, 0};
    ph[5] = 1 + int'(xs() % pl[5]);
    for (int k = 0; k < 6; k++)
    begin
      wr(tmrb_pkg::IDX_CTRLA, 32'h00000000);
      wr(tmrb_pkg::IDX_COMPARE, {16'h0000, 8'(ph[k]), 8'(pl[k])});
      wr(tmrb_pkg::IDX_COUNT, 32'h00000000);
      wr(tmrb_pkg::IDX_CTRLB, 32'h00000017);
      wr(tmrb_pkg::IDX_CTRLA, 32'h00000001);
      repeat (2 * pl[k] + 8) @(posedge hclk);
      hc = 0;
      repeat (4 * (pl[k] + 1)) begin @(posedge hclk); hc += int'(wf === 1'b1); end
      cmp(32'(hc), 32'(pl[k] == 0 ? 0 : 4 * (ph[k] < pl[k] + 1 ? ph[k] : pl[k] + 1)));
    end
    // Other modes show the initial level; drive enable off forces zero
    wr(tmrb_pkg::IDX_CTRLA, 32'h00000000);
    wr(tmrb_pkg::IDX_CTRLB, 32'h00000020);
    repeat (3) @(posedge hclk);
    cmp({31'h0, wf}, 32'h00000000);
    wr(tmrb_pkg::IDX_CTRLB, 32'h00000030);
    repeat (3) @(posedge hclk);
    cmp({31'h0, wf}, 32'h00000001);
    wr(tmrb_pkg::IDX_COMPARE, 32'h0000FFFF);
    wr(tmrb_pkg::IDX_COUNT, 32'h00000000);
    wr(tmrb_pkg::IDX_CTRLA, 32'h00000011);
    repeat (30) @(posedge hclk);
    do @(posedge hclk); while (crs !== 1'b1);
    rd(tmrb_pkg::IDX_COUNT, q);
    ok(q < 32'h00000008);
    end_sim();
  end
endmodule
